// *** rtl/uabd_presc.sv ***
// Oscillator prescaler giving base and measurement clock ticks
`timescale 1ns/1ps
module uabd_presc (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       ce,
   input  wire logic [1:0] sel,
   output logic            base_tick,
   output logic            abd_tick
);
   logic [uabd_pkg::PRE_W-1:0] cnt_q;
   logic [uabd_pkg::PRE_W-1:0] base_msk;
   logic [uabd_pkg::PRE_W-1:0] abd_msk;

   // Free-running count; ticks are taken from its low bits
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= '0;
      end else if (ce) begin
         cnt_q <= cnt_q + 1'b1;
      end
   end

   // Mask choice per divider-select code
   always_comb begin
      unique case (sel)
         uabd_pkg::SEL_ONE: begin
            base_msk = uabd_pkg::BASE_MSK_16;
            abd_msk  = uabd_pkg::ABD_MSK_128;
         end
         uabd_pkg::SEL_BOTH: begin
            base_msk = uabd_pkg::BASE_MSK_4;
            abd_msk  = uabd_pkg::ABD_MSK_32;
         end
         default: begin
            base_msk = uabd_pkg::BASE_MSK_64;
            abd_msk  = uabd_pkg::ABD_MSK_512;
         end
      endcase
   end

   // Measurement tick is always one of every eight base ticks
   assign base_tick = ce & ((cnt_q & base_msk) == base_msk);
   assign abd_tick  = ce & ((cnt_q & abd_msk) == abd_msk);
endmodule // uabd_presc

// *** rtl/uabd_sync.sv ***
// Receive line synchroniser with edge detection
`timescale 1ns/1ps
module uabd_sync (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic ce,
   input  wire logic d,
   output logic      q,
   output logic      rise,
   output logic      fall
);
   logic meta_q;
   logic sync_q;
   logic prev_q;

   // Two stages; only the second stage feeds edge logic
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= 1'b1;
         sync_q <= 1'b1;
         prev_q <= 1'b1;
      end else if (ce) begin
         meta_q <= d;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   // Edges from settled copies; gated by ce so a frozen block sees none
   assign q    = sync_q;
   assign rise = ce & sync_q & ~prev_q;
   assign fall = ce & ~sync_q & prev_q;
endmodule // uabd_sync

// *** rtl/uabd_top.sv ***
// Auto-baud measurement unit with APB registers and baud generator
//
// The implementer's own choices: the register addresses and the APB register port.
`timescale 1ns/1ps
// Function
// - While armed, receive line edges time the divider counter instead of sampling.
// - Setting arm starts calibration; receiver state machine is held idle meanwhile.
// - Counting starts at first rising edge after start bit, on measurement clock.
// - Counting stops on fifth rising edge; count stays in divider pair.
// - Completion clears arm bit and sets receive flag together.
// - Reading receive data clears receive flag; software discards the byte.
// - Full count visible in both bytes so high byte zero confirms fit.
// - Both divider bytes form one 16-bit counter whatever the width select.
// - Measurement counter advances at one eighth of the base clock.
// - Select bits pick base/measure clocks: /64,/512; /16,/128; /4,/32.
// - Final count equals average bit time at full-speed divider clock.
// - With wake-on-break also set, measure the character after the break.
// - Counter starts at one; software subtracts one afterwards.
// - Overflow before fifth edge sets flag; counting continues to fifth edge.
// - Overflow flag refuses clearing while arm bit is still set.
module uabd_top (
   input  wire logic        CLK,
   input  wire logic        ARST_N,
   input  wire logic        CE,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [7:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   output logic      [31:0] PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   input  wire logic        RX,
   output logic             IRQ,
   output logic             BAUD_TICK,
   output logic             RX_HOLD_IDLE
);
   logic                  rst_meta_q;
   logic                  rst_n_q;
   logic                  rx_lvl;
   logic                  rx_rise;
   logic                  rx_fall;
   logic                  base_tick;
   logic                  abd_tick;
   logic [1:0]            sel;
   logic                  arm_q;
   logic                  wue_q;
   logic                  wide_q;
   logic                  hspd_q;
   logic                  ovf_q;
   logic                  rcv_q;
   logic [15:0]           div_q;
   logic [15:0]           brg_cnt_q;
   logic [15:0]           divisor;
   logic [2:0]            rise_cnt_q;
   logic [uabd_pkg::EVT_W-1:0] evt_q;
   logic [uabd_pkg::EVT_W-1:0] mask_q;
   logic [uabd_pkg::EVT_W-1:0] evt_set;
   uabd_pkg::uabd_state_e state_q;
   uabd_pkg::uabd_state_e state_d;
   logic                  measuring;
   logic                  done;
   logic                  ovf_hit;
   logic                  wake_fall;
   logic                  brk_end;
   logic                  acc;
   logic                  wr;
   logic                  rd;
   logic                  mapped;
   logic [31:0]           rdata;

   // Reset release through two flops; assertion stays asynchronous
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         rst_meta_q <= 1'b0;
         rst_n_q    <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n_q    <= rst_meta_q;
      end
   end

   // Receive line crosses in from the pin
   uabd_sync u_sync (
      .clk  (CLK),
      .rst_n(rst_n_q),
      .ce   (CE),
      .d    (RX),
      .q    (rx_lvl),
      .rise (rx_rise),
      .fall (rx_fall)
   );

   assign sel = {wide_q & hspd_q, wide_q ^ hspd_q};

   uabd_presc u_presc (
      .clk      (CLK),
      .rst_n    (rst_n_q),
      .ce       (CE),
      .sel      (sel),
      .base_tick(base_tick),
      .abd_tick (abd_tick)
   );

   // APB access phase; completes on the second access cycle
   assign acc    = PSEL & PENABLE & PREADY;
   assign wr     = acc & PWRITE;
   assign rd     = acc & ~PWRITE;
   assign mapped = (PADDR == uabd_pkg::OFS_CTRL)   || (PADDR == uabd_pkg::OFS_DIV_LO) ||
                   (PADDR == uabd_pkg::OFS_DIV_HI) || (PADDR == uabd_pkg::OFS_RXDATA) ||
                   (PADDR == uabd_pkg::OFS_FLAGS)  || (PADDR == uabd_pkg::OFS_EVT)    ||
                   (PADDR == uabd_pkg::OFS_MASK);

   // Sequencer next state
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         uabd_pkg::ST_IDLE: begin
            if (wue_q) begin
               state_d = uabd_pkg::ST_BRK_FALL;
            end else if (arm_q) begin
               state_d = uabd_pkg::ST_START;
            end
         end
         uabd_pkg::ST_BRK_FALL: begin
            if (!wue_q) begin
               state_d = uabd_pkg::ST_IDLE;
            end else if (rx_fall) begin
               state_d = uabd_pkg::ST_BRK_RISE;
            end
         end
         uabd_pkg::ST_BRK_RISE: begin
            if (!wue_q || rx_rise) begin
               state_d = uabd_pkg::ST_IDLE;
            end
         end
         uabd_pkg::ST_START: begin
            if (!arm_q) begin
               state_d = uabd_pkg::ST_IDLE;
            end else if (rx_fall) begin
               state_d = uabd_pkg::ST_FIRST_RISE;
            end
         end
         uabd_pkg::ST_FIRST_RISE: begin
            if (!arm_q) begin
               state_d = uabd_pkg::ST_IDLE;
            end else if (rx_rise) begin
               state_d = uabd_pkg::ST_COUNT;
            end
         end
         uabd_pkg::ST_COUNT: begin
            if (!arm_q || done) begin
               state_d = uabd_pkg::ST_IDLE;
            end
         end
         default: state_d = uabd_pkg::ST_IDLE;
      endcase
   end

   assign done      = (state_q == uabd_pkg::ST_COUNT) & arm_q & rx_rise & (rise_cnt_q == uabd_pkg::RISE_LAST);
   assign ovf_hit   = (state_q == uabd_pkg::ST_COUNT) & arm_q & abd_tick & ~done & (div_q == uabd_pkg::DIV_MAX);
   assign wake_fall = (state_q == uabd_pkg::ST_BRK_FALL) & wue_q & rx_fall;
   assign brk_end   = (state_q == uabd_pkg::ST_BRK_RISE) & wue_q & rx_rise;
   assign measuring = (state_q == uabd_pkg::ST_FIRST_RISE) | (state_q == uabd_pkg::ST_COUNT);

   // Sequencer state register
   always_ff @(posedge CLK or negedge rst_n_q) begin
      if (!rst_n_q) begin
         state_q <= uabd_pkg::ST_IDLE;
      end else if (CE) begin
         state_q <= state_d;
      end
   end

   // Rising edges seen since counting began
   always_ff @(posedge CLK or negedge rst_n_q) begin
      if (!rst_n_q) begin
         rise_cnt_q <= '0;
      end else if (CE) begin
         if (state_q == uabd_pkg::ST_FIRST_RISE && rx_rise) begin
            rise_cnt_q <= uabd_pkg::RISE_FIRST;
         end else if (state_q == uabd_pkg::ST_COUNT && rx_rise) begin
            rise_cnt_q <= rise_cnt_q + 1'b1;
         end
      end
   end

   // Control bits; a software write of arm wins over the hardware clear
   always_ff @(posedge CLK or negedge rst_n_q) begin
      if (!rst_n_q) begin
         arm_q  <= 1'b0;
         wue_q  <= 1'b0;
         wide_q <= 1'b0;
         hspd_q <= 1'b0;
      end else if (CE) begin
         if (wr && PADDR == uabd_pkg::OFS_CTRL) begin
            arm_q  <= PWDATA[uabd_pkg::CTL_ARM];
            wue_q  <= PWDATA[uabd_pkg::CTL_WUE];
            wide_q <= PWDATA[uabd_pkg::CTL_WIDE];
            hspd_q <= PWDATA[uabd_pkg::CTL_HSPD];
         end else begin
            if (done) begin
               arm_q <= 1'b0;
            end
            // Break over: wake enable drops on line rising
            if (brk_end) begin
               wue_q <= 1'b0;
            end
         end
      end
   end

   // Overflow flag; set wins over a clear in the same cycle
   always_ff @(posedge CLK or negedge rst_n_q) begin
      if (!rst_n_q) begin
         ovf_q <= 1'b0;
      end else if (CE) begin
         if (ovf_hit) begin
            ovf_q <= 1'b1;
         end else if (wr && PADDR == uabd_pkg::OFS_CTRL && !PWDATA[uabd_pkg::CTL_OVF] && !arm_q) begin
            ovf_q <= 1'b0;
         end
      end
   end

   // Receive flag; a data read clears it unless a new set arrives
   always_ff @(posedge CLK or negedge rst_n_q) begin
      if (!rst_n_q) begin
         rcv_q <= 1'b0;
      end else if (CE) begin
         if (done || wake_fall) begin
            rcv_q <= 1'b1;
         end else if (rd && PADDR == uabd_pkg::OFS_RXDATA) begin
            rcv_q <= 1'b0;
         end
      end
   end

   // Divider pair: software bytes, or the measurement counter when armed
   always_ff @(posedge CLK or negedge rst_n_q) begin
      if (!rst_n_q) begin
         div_q <= uabd_pkg::DIV_RESET;
      end else if (CE) begin
         if (state_q == uabd_pkg::ST_FIRST_RISE && arm_q && rx_rise) begin
            div_q <= uabd_pkg::DIV_START;
         end else if (state_q == uabd_pkg::ST_COUNT && arm_q && abd_tick && !done) begin
            div_q <= div_q + 1'b1;
         end else if (!measuring && wr && PADDR == uabd_pkg::OFS_DIV_LO) begin
            div_q[7:0] <= PWDATA[7:0];
         end else if (!measuring && wr && PADDR == uabd_pkg::OFS_DIV_HI) begin
            div_q[15:8] <= PWDATA[7:0];
         end
      end
   end

   // Normal baud generator; narrow mode ignores the high byte
   assign divisor = wide_q ? div_q : {8'h00, div_q[7:0]};

   always_ff @(posedge CLK or negedge rst_n_q) begin
      if (!rst_n_q) begin
         brg_cnt_q <= uabd_pkg::DIV_RESET;
         BAUD_TICK <= 1'b0;
      end else if (CE) begin
         BAUD_TICK <= 1'b0;
         // generator idle while armed; no stray ticks before the start bit
         if (measuring || arm_q) begin
            brg_cnt_q <= uabd_pkg::DIV_RESET;
         end else if (base_tick) begin
            if (brg_cnt_q == uabd_pkg::DIV_RESET) begin
               brg_cnt_q <= divisor;
               BAUD_TICK <= 1'b1;
            end else begin
               brg_cnt_q <= brg_cnt_q - 1'b1;
            end
         end
      end
   end

   always_ff @(posedge CLK or negedge rst_n_q) begin
      if (!rst_n_q) begin
         RX_HOLD_IDLE <= 1'b0;
      end else if (CE) begin
         RX_HOLD_IDLE <= arm_q | wue_q | (state_d != uabd_pkg::ST_IDLE);
      end
   end

   // Sticky events, one per bit, write one to clear, set wins
   assign evt_set[uabd_pkg::EVT_DONE] = done;
   assign evt_set[uabd_pkg::EVT_OVF]  = ovf_hit;
   assign evt_set[uabd_pkg::EVT_BRK]  = brk_end;

   genvar gi;
   generate
      for (gi = 0; gi < uabd_pkg::EVT_W; gi++) begin : g_evt
         always_ff @(posedge CLK or negedge rst_n_q) begin
            if (!rst_n_q) begin
               evt_q[gi] <= 1'b0;
            end else if (CE) begin
               if (evt_set[gi]) begin
                  evt_q[gi] <= 1'b1;
               end else if (wr && PADDR == uabd_pkg::OFS_EVT && PWDATA[gi]) begin
                  evt_q[gi] <= 1'b0;
               end
            end
         end
      end
   endgenerate

   // Mask register and level interrupt
   always_ff @(posedge CLK or negedge rst_n_q) begin
      if (!rst_n_q) begin
         mask_q <= '0;
         IRQ    <= 1'b0;
      end else if (CE) begin
         if (wr && PADDR == uabd_pkg::OFS_MASK) begin
            mask_q <= PWDATA[uabd_pkg::EVT_W-1:0];
         end
         IRQ <= |(evt_q & mask_q);
      end
   end

   // Read multiplexer; both bytes always readable
   always_comb begin
      rdata = '0;
      unique case (PADDR)
         uabd_pkg::OFS_CTRL: begin
            rdata[uabd_pkg::CTL_ARM]  = arm_q;
            rdata[uabd_pkg::CTL_WUE]  = wue_q;
            rdata[uabd_pkg::CTL_WIDE] = wide_q;
            rdata[uabd_pkg::CTL_HSPD] = hspd_q;
            rdata[uabd_pkg::CTL_OVF]  = ovf_q;
         end
         uabd_pkg::OFS_DIV_LO: rdata[7:0] = div_q[7:0];
         uabd_pkg::OFS_DIV_HI: rdata[7:0] = div_q[15:8];
         uabd_pkg::OFS_RXDATA: rdata[7:0] = uabd_pkg::RXDATA_VAL;
         uabd_pkg::OFS_FLAGS: begin
            rdata[uabd_pkg::FLG_RCV]   = rcv_q;
            rdata[uabd_pkg::FLG_BUSY]  = measuring;
            rdata[uabd_pkg::FLG_RXLVL] = rx_lvl;
         end
         uabd_pkg::OFS_EVT:  rdata[uabd_pkg::EVT_W-1:0] = evt_q;
         uabd_pkg::OFS_MASK: rdata[uabd_pkg::EVT_W-1:0] = mask_q;
         default: rdata = '0;
      endcase
   end

   // APB answer: one wait cycle, data and error registered
   always_ff @(posedge CLK or negedge rst_n_q) begin
      if (!rst_n_q) begin
         PREADY  <= 1'b0;
         PRDATA  <= '0;
         PSLVERR <= 1'b0;
      end else if (CE) begin
         PREADY  <= PSEL & PENABLE & ~PREADY;
         PSLVERR <= PSEL & PENABLE & ~PREADY & ~mapped;
         if (PSEL && PENABLE && !PREADY && !PWRITE) begin
            PRDATA <= rdata;
         end
      end
   end
endmodule // uabd_top

// *** shared/uabd_pkg.sv ***
// Constants and types shared by the auto-baud measurement block
package uabd_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL    = 8'h00;
   localparam logic [7:0] OFS_DIV_LO  = 8'h04;
   localparam logic [7:0] OFS_DIV_HI  = 8'h08;
   localparam logic [7:0] OFS_RXDATA  = 8'h0C;
   localparam logic [7:0] OFS_FLAGS   = 8'h10;
   localparam logic [7:0] OFS_EVT     = 8'h14;
   localparam logic [7:0] OFS_MASK    = 8'h18;
   // Control register bit positions
   localparam int CTL_ARM   = 0;
   localparam int CTL_WUE   = 1;
   localparam int CTL_WIDE  = 2;
   localparam int CTL_HSPD  = 3;
   localparam int CTL_OVF   = 4;
   // Flag register bit positions
   localparam int FLG_RCV   = 0;
   localparam int FLG_BUSY  = 1;
   localparam int FLG_RXLVL = 2;
   // Event status and mask bit positions
   localparam int EVT_DONE  = 0;
   localparam int EVT_OVF   = 1;
   localparam int EVT_BRK   = 2;
   localparam int EVT_W     = 3;
   // Reset values and counter constants
   localparam logic [15:0] DIV_RESET   = 16'h0000;
   localparam logic [15:0] DIV_START   = 16'h0001;
   localparam logic [15:0] DIV_MAX     = 16'hFFFF;
   localparam logic [2:0]  RISE_FIRST  = 3'h1;
   localparam logic [2:0]  RISE_LAST   = 3'h4;
   localparam logic [7:0]  RXDATA_VAL  = 8'h00;
   // Prescaler masks: base clock and measurement clock (eight times slower)
   localparam int          PRE_W        = 9;
   localparam logic [8:0]  BASE_MSK_64  = 9'h03F;
   localparam logic [8:0]  BASE_MSK_16  = 9'h00F;
   localparam logic [8:0]  BASE_MSK_4   = 9'h003;
   localparam logic [8:0]  ABD_MSK_512  = 9'h1FF;
   localparam logic [8:0]  ABD_MSK_128  = 9'h07F;
   localparam logic [8:0]  ABD_MSK_32   = 9'h01F;
   // Divider-select codes: none, exactly one, both bits set
   localparam logic [1:0]  SEL_NONE = 2'h0;
   localparam logic [1:0]  SEL_ONE  = 2'h1;
   localparam logic [1:0]  SEL_BOTH = 2'h2;
   // Measurement sequencer states
   typedef enum logic [2:0] {
      ST_IDLE       = 3'b000,
      ST_BRK_FALL   = 3'b001,
      ST_BRK_RISE   = 3'b010,
      ST_START      = 3'b011,
      ST_FIRST_RISE = 3'b100,
      ST_COUNT      = 3'b101
   } uabd_state_e;
endpackage

// *** test/testbench.sv ***
// Self-checking bench for the auto-baud unit
`timescale 1ns/1ps
module testbench;
   logic        CLK, ARST_N, CE, PSEL, PENABLE, PWRITE, RX, IRQ, BAUD_TICK, RX_HOLD_IDLE, PREADY, PSLVERR;
   logic [7:0]  PADDR;
   logic [31:0] PWDATA, PRDATA, rd, ctl;
   logic        go, brk, busy, err;
   logic [15:0] bit_cyc;
   int          mismatches, tests_run, n;

   uabd_top uut (.CLK(CLK), .ARST_N(ARST_N), .CE(CE), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
      .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .RX(RX),
      .IRQ(IRQ), .BAUD_TICK(BAUD_TICK), .RX_HOLD_IDLE(RX_HOLD_IDLE));
   uabd_txmodel u_tx (.clk(CLK), .go(go), .brk(brk), .bit_cyc(bit_cyc), .rx(RX), .busy(busy));

   // Clock of 100 ns period
   initial begin
      CLK = 1'b0;
      forever #50 CLK = ~CLK;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Phase of the measure tick is free, so the count has a window
   task automatic chk_rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
      tests_run++;
      if ((got >= lo && got <= hi) !== 1'b1) begin
         mismatches++;
         $display("[ERR] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
      end
   endtask

   // One APB transfer; waits for PREADY, bounded
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      n = 0;
      PSEL   <= 1'b1;
      PWRITE <= wr;
      PADDR  <= a;
      PWDATA <= wd;
      @(posedge CLK);
      PENABLE <= 1'b1;
      do begin
         @(posedge CLK);
         n++;
      end while (PREADY !== 1'b1 && n < 50);
      if (n >= 50)
         mismatches++;
      rd = PRDATA;
      err = PSLVERR;
      PSEL    <= 1'b0;
      PENABLE <= 1'b0;
      @(posedge CLK);
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask

   // Frame from the remote side, then time for the flags to land
   task automatic send(input logic b, input logic [15:0] t);
      brk     <= b;
      bit_cyc <= t;
      go      <= 1'b1;
      @(posedge CLK);
      go <= 1'b0;
      repeat (2) @(posedge CLK);
      n = 0;
      while (busy && n < 20000) begin
         @(posedge CLK);
         n++;
      end
      repeat (8) @(posedge CLK);
   endtask

   task automatic test_done();
      $display("checks %0d, mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // Hang guard, well above the few thousand cycles needed
   initial begin
      repeat (40000) @(posedge CLK);
      mismatches++;
      test_done();
   end

   initial begin
      ARST_N = 1'b0;
      CE = 1'b1;
      PSEL = 1'b0;
      PENABLE = 1'b0;
      PWRITE = 1'b0;
      PADDR = 8'h00;
      PWDATA = 32'h0;
      go = 1'b0;
      brk = 1'b0;
      bit_cyc = 16'h0040;
      repeat (4) @(posedge CLK);
      ARST_N <= 1'b1;
      repeat (3) @(posedge CLK);
      // Reset values; flags show the idle-high line
      for (int i = 0; i < 7; i++)
         rdchk(8'(i * 4), (i == 4) ? 32'h4 : 32'h0);
      bus(1'b0, 8'h1C, 32'h0);
      chk(32'(err), 32'h1);
      $display("test 1 done");
      // Each divider-select code in turn: /512, /128, /32
      bus(1'b1, uabd_pkg::OFS_MASK, 32'h1);
      for (int s = 0; s < 3; s++) begin
         ctl = (s == 0) ? 32'h1 : ((s == 1) ? 32'h9 : 32'hD);
         bus(1'b1, uabd_pkg::OFS_CTRL, ctl);
         @(posedge CLK);
         chk(32'(RX_HOLD_IDLE), 32'h1);
         send(1'b0, 16'h0100 >> s);
         rdchk(uabd_pkg::OFS_CTRL, ctl & 32'hE);
         bus(1'b0, uabd_pkg::OFS_FLAGS, 32'h0);
         chk(rd & 32'h1, 32'h1);
         chk(32'(IRQ), 32'h1);
         rdchk(uabd_pkg::OFS_DIV_HI, 32'h0);
         bus(1'b0, uabd_pkg::OFS_DIV_LO, 32'h0);
         chk_rng(rd, 32'h4 << s, (32'h4 << s) + 32'h2);
         rdchk(uabd_pkg::OFS_RXDATA, 32'h0);
         bus(1'b0, uabd_pkg::OFS_FLAGS, 32'h0);
         chk(rd & 32'h1, 32'h0);
         rdchk(uabd_pkg::OFS_EVT, 32'h1);
         bus(1'b1, uabd_pkg::OFS_EVT, 32'h1);
         @(posedge CLK);
         chk(32'(IRQ), 32'h0);
      end
      $display("test 2 done");
      // Wake on break with arm, events masked, then unmasked
      bus(1'b1, uabd_pkg::OFS_MASK, 32'h0);
      bus(1'b1, uabd_pkg::OFS_CTRL, 32'hF);
      send(1'b1, 16'h0040);
      rdchk(uabd_pkg::OFS_CTRL, 32'hC);
      rdchk(uabd_pkg::OFS_EVT, 32'h5);
      chk(32'(IRQ), 32'h0);
      bus(1'b0, uabd_pkg::OFS_DIV_LO, 32'h0);
      chk_rng(rd, 32'h10, 32'h12);
      bus(1'b1, uabd_pkg::OFS_MASK, 32'h5);
      @(posedge CLK);
      chk(32'(IRQ), 32'h1);
      bus(1'b1, uabd_pkg::OFS_EVT, 32'h5);
      rdchk(uabd_pkg::OFS_EVT, 32'h0);
      $display("test 3 done");
      // Unarmed: line ignored, divisor 3 at /4 gives ticks 16 apart
      bus(1'b1, uabd_pkg::OFS_DIV_LO, 32'h3);
      send(1'b0, 16'h0040);
      rdchk(uabd_pkg::OFS_DIV_LO, 32'h3);
      n = 0;
      while (BAUD_TICK !== 1'b1 && n < 100) begin
         @(posedge CLK);
         n++;
      end
      n = 0;
      do begin
         @(posedge CLK);
         n++;
      end while (BAUD_TICK !== 1'b1 && n < 100);
      chk(32'(n), 32'h10);
      // Clock enable low freezes the generator
      CE <= 1'b0;
      n = 0;
      repeat (40) begin
         @(posedge CLK);
         if (BAUD_TICK === 1'b1)
            n++;
      end
      CE <= 1'b1;
      chk(32'(n), 32'h0);
      $display("test 4 done");
      test_done();
   end
endmodule // testbench

// *** test/uabd_monitor.sv ***
// Port-level checker for the auto-baud unit, bound to its top
`timescale 1ns/1ps
module uabd_monitor (
   input wire logic        CLK,
   input wire logic        ARST_N,
   input wire logic        CE,
   input wire logic        PSEL,
   input wire logic        PENABLE,
   input wire logic        PWRITE,
   input wire logic [7:0]  PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [31:0] PRDATA,
   input wire logic        PREADY,
   input wire logic        PSLVERR,
   input wire logic        RX,
   input wire logic        IRQ,
   input wire logic        BAUD_TICK,
   input wire logic        RX_HOLD_IDLE
);
   logic mask_q;
   logic arm_q;
   wire  wr_done = PSEL && PENABLE && PREADY && PWRITE;
   // Mask shadow from completed writes
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N)
         mask_q <= 1'b0;
      else if (wr_done && PADDR == uabd_pkg::OFS_MASK)
         mask_q <= |PWDATA[2:0];
   end
   // Software arm shadow; dropped when the unit lets the receiver go
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N)
         arm_q <= 1'b0;
      else if (wr_done && PADDR == uabd_pkg::OFS_CTRL)
         arm_q <= PWDATA[uabd_pkg::CTL_ARM];
      else if ($fell(RX_HOLD_IDLE))
         arm_q <= 1'b0;
   end
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!ARST_N);
   property p_ready_pulse;
      PREADY |=> !PREADY;
   endproperty
   a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");
   property p_ready_time;
      PSEL && !PENABLE && CE ##1 PSEL && PENABLE && CE |=> PREADY;
   endproperty
   a_ready_time: assert property (p_ready_time) else $error("access not ended in two cycles");
   property p_err_cause;
      PSLVERR |-> PREADY && PADDR > uabd_pkg::OFS_MASK;
   endproperty
   a_err_cause: assert property (p_err_cause) else $error("error on a mapped place");
   property p_err_unmapped;
      PREADY && PADDR > uabd_pkg::OFS_MASK |-> PSLVERR;
   endproperty
   a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped access not refused");
   property p_rxdata_zero;
      PREADY && !PWRITE && PADDR == uabd_pkg::OFS_RXDATA |-> PRDATA == 32'h0;
   endproperty
   a_rxdata_zero: assert property (p_rxdata_zero) else $error("receive data not zero");
   property p_irq_masked;
      !mask_q && !$past(mask_q) |-> !IRQ;
   endproperty
   a_irq_masked: assert property (p_irq_masked) else $error("interrupt with all masked");
   property p_hold_on_arm;
      wr_done && PADDR == uabd_pkg::OFS_CTRL && PWDATA[uabd_pkg::CTL_ARM] |-> ##[1:2] RX_HOLD_IDLE;
   endproperty
   a_hold_on_arm: assert property (p_hold_on_arm) else $error("receiver not held on arm");
   property p_no_tick_armed;
      arm_q && RX_HOLD_IDLE && $past(RX_HOLD_IDLE) |-> !BAUD_TICK;
   endproperty
   a_no_tick_armed: assert property (p_no_tick_armed) else $error("baud tick while measuring");
   property p_tick_gap;
      BAUD_TICK |=> !BAUD_TICK [*3];
   endproperty
   a_tick_gap: assert property (p_tick_gap) else $error("baud ticks closer than four");
   c_arm: cover property (wr_done && PADDR == uabd_pkg::OFS_CTRL && PWDATA[uabd_pkg::CTL_ARM]);
   c_done: cover property ($fell(RX_HOLD_IDLE));
   c_irq: cover property (IRQ);
   c_err: cover property (PSLVERR);
endmodule // uabd_monitor

bind uabd_top uabd_monitor u_mon (.CLK(CLK), .ARST_N(ARST_N), .CE(CE), .PSEL(PSEL), .PENABLE(PENABLE),
   .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
   .RX(RX), .IRQ(IRQ), .BAUD_TICK(BAUD_TICK), .RX_HOLD_IDLE(RX_HOLD_IDLE));

// *** test/uabd_txmodel.sv ***
// Remote transmitter model: optional break, then the sync byte
`timescale 1ns/1ps
module uabd_txmodel (
   input  wire logic        clk,
   input  wire logic        go,
   input  wire logic        brk,
   input  wire logic [15:0] bit_cyc,
   output logic             rx,
   output logic             busy
);
   logic [9:0] frame;
   // Line rests high, as its pull-up holds it between frames
   initial begin
      rx = 1'b1;
      busy = 1'b0;
      forever begin
         @(posedge clk);
         if (go) begin
            busy <= 1'b1;
            // break of twelve low bits, then idle
            if (brk) begin
               rx <= 1'b0;
               repeat (12 * bit_cyc) @(posedge clk);
               rx <= 1'b1;
               repeat (2 * bit_cyc) @(posedge clk);
            end
            // sync byte 55h at a rate the clock can measure
            frame = {1'b1, 8'h55, 1'b0};
            for (int i = 0; i < 10; i++) begin
               rx <= frame[i];
               repeat (bit_cyc) @(posedge clk);
            end
            busy <= 1'b0;
         end
      end
   end
endmodule // uabd_txmodel
